// >>> lpc_pkg.sv
package lpc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Counts, group sizes and field widths
    localparam int LPC_NUM_TMR = 8;
    localparam int LPC_NUM_CH = 16;
    localparam int LPC_GRP_TMR = 4;
    localparam int LPC_GRP_CH = 8;
    localparam int LPC_RES_W = 4;
    localparam int LPC_CNT_W = 15;
    localparam int LPC_DIV_W = 10;
    localparam int LPC_FADE_W = 10;
    localparam int LPC_RES_MIN = 1;
    localparam int LPC_RES_MAX = 15;

    ////////////////////////////////////////////////////////////////////////
    // Timing figures, clock rate and fastest output
    localparam int LPC_CLK_HZ = 100_000_000;
    localparam int LPC_FOUT_MAX_HZ = 40_000_000;
    localparam int LPC_FOUT_MAX_CYC = (LPC_CLK_HZ + LPC_FOUT_MAX_HZ - 1)
                                      / LPC_FOUT_MAX_HZ;

    ////////////////////////////////////////////////////////////////////////
    // Byte addresses on the register bus, and word indices within a channel
    localparam logic [11:0] LPC_TMR_BASE = 12'h000;
    localparam logic [11:0] LPC_INT_ST_ADDR = 12'h080;
    localparam logic [11:0] LPC_INT_MASK_ADDR = 12'h084;
    localparam logic [11:0] LPC_CH_BASE = 12'h100;
    localparam logic [1:0] LPC_CH_W_CONF = 2'h0;
    localparam logic [1:0] LPC_CH_W_DUTY = 2'h1;
    localparam logic [1:0] LPC_CH_W_FADE = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Register layouts
    typedef struct packed {
        logic rsv_hi;
        logic upd;
        logic rst;
        logic pause;
        logic [1:0] rsv_mid;
        logic [LPC_DIV_W-1:0] div;
        logic [11:0] rsv_lo;
        logic [LPC_RES_W-1:0] res;
    } lpc_tmr_cfg_s;

    typedef struct packed {
        logic [25:0] rsv_hi;
        logic upd;
        logic idle;
        logic run;
        logic rsv_lo;
        logic [1:0] tsel;
    } lpc_ch_cfg_s;

    typedef struct packed {
        logic dir;
        logic rsv;
        logic [LPC_FADE_W-1:0] scale;
        logic [LPC_FADE_W-1:0] cyc;
        logic [LPC_FADE_W-1:0] steps;
    } lpc_fade_s;

    // Writable bits; update strobes are never stored
    localparam logic [31:0] LPC_TMR_WMASK = 32'h33FF000F;
    localparam logic [31:0] LPC_CH_WMASK = 32'h0000001B;
    localparam logic [31:0] LPC_FADE_WMASK = 32'hBFFFFFFF;
    localparam logic [LPC_RES_W-1:0] LPC_RES_RST = 4'hD;

    // Top count of a timer at a given resolution
    function automatic logic [LPC_CNT_W-1:0] lpc_res_max(
        input logic [LPC_RES_W-1:0] res);
        logic [LPC_RES_W-1:0] r;
        r = (res < LPC_RES_W'(LPC_RES_MIN)) ? LPC_RES_W'(LPC_RES_MIN) : res;
        return LPC_CNT_W'((16'h1 << r) - 16'h1); // see RULE8
    endfunction : lpc_res_max

endpackage : lpc_pkg

// >>> lpc_chan.sv
`timescale 1ns/1ps
module lpc_chan import lpc_pkg::*; (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // Bound timer
    input wire logic [LPC_CNT_W-1:0] cnt_in,
    input wire logic ovf_in,
    input wire logic [LPC_RES_W-1:0] res_in,
    // Settings
    input wire lpc_ch_cfg_s cfg_in,
    input wire logic upd_in,
    input wire logic [LPC_CNT_W-1:0] duty_in,
    input wire lpc_fade_s fade_in,
    // Results
    output logic [LPC_CNT_W-1:0] duty_out,
    output logic pwm_out,
    output logic done_out
);

    ////////////////////////////////////////////////////////////////////////
    // Fade state
    logic [LPC_FADE_W-1:0] steps_left;
    logic [LPC_FADE_W-1:0] cyc_cnt;
    logic [LPC_FADE_W-1:0] cyc;
    logic [LPC_FADE_W-1:0] scale;
    logic dir;
    logic fading;

    ////////////////////////////////////////////////////////////////////////
    // Duty arithmetic, saturating at both ends
    wire [LPC_CNT_W-1:0] dmax = lpc_res_max(res_in);
    wire [LPC_CNT_W-1:0] duty_cl = (duty_in > dmax) ? dmax : duty_in;
    wire [LPC_CNT_W-1:0] scale_w = LPC_CNT_W'(scale);
    wire [LPC_CNT_W:0] up_sum = {1'b0, duty_out} + {1'b0, scale_w};
    wire [LPC_CNT_W-1:0] up_d = (up_sum > {1'b0, dmax}) ? dmax
                                : up_sum[LPC_CNT_W-1:0];
    wire [LPC_CNT_W-1:0] dn_d = (duty_out < scale_w) ? '0
                                : LPC_CNT_W'(duty_out - scale_w);
    // A rebind to a coarser timer clips instead of saturating the output
    wire [LPC_CNT_W-1:0] duty_lim = (duty_out > dmax) ? dmax : duty_out;
    // One bit resolution leaves only the square wave
    wire [LPC_CNT_W-1:0] eff_duty = (dmax == LPC_CNT_W'(1)) ? LPC_CNT_W'(1)
                                    : duty_lim; // see RULE6
    // Zero periods per step is taken as one
    wire cyc_hit = ({1'b0, cyc_cnt} + 11'h001) >= {1'b0, cyc};
    wire step_now = fading & cfg_in.run & ovf_in & cyc_hit;
    wire last_step = step_now & (steps_left == LPC_FADE_W'(1));

    ////////////////////////////////////////////////////////////////////////
    // Output pin and completion pulse
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            pwm_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            pwm_out <= cfg_in.run ? (cnt_in < eff_duty)
                                  : cfg_in.idle; // see RULE13 RULE17
            done_out <= last_step; // see RULE10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pending settings adopted only on update, then fade steps
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            duty_out <= '0;
            steps_left <= '0;
            cyc_cnt <= '0;
            cyc <= '0;
            scale <= '0;
            dir <= 1'b0;
            fading <= 1'b0;
        end else if (upd_in) begin
            duty_out <= duty_cl; // see RULE5 RULE4
            steps_left <= fade_in.steps; // see RULE16
            cyc <= fade_in.cyc;
            scale <= fade_in.scale;
            dir <= fade_in.dir;
            cyc_cnt <= '0;
            fading <= (fade_in.steps != '0);
        end else if (step_now) begin
            duty_out <= dir ? up_d : dn_d; // see RULE9 RULE15
            cyc_cnt <= '0;
            steps_left <= LPC_FADE_W'(steps_left - 1'b1);
            fading <= !last_step; // see RULE18
        end else if (fading & cfg_in.run & ovf_in) begin
            cyc_cnt <= LPC_FADE_W'(cyc_cnt + 1'b1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_duty_in_range: assert property ( // see RULE4
        @(posedge core_clk_in) disable iff (!resetn_in)
        upd_in |=> duty_out <= dmax)
        else $error("duty left its range after update");
    a_idle_level: assert property ( // see RULE13
        @(posedge core_clk_in) disable iff (!resetn_in)
        !cfg_in.run ##1 !$past(cfg_in.run) |-> pwm_out == $past(cfg_in.idle))
        else $error("stopped channel not at idle level");
    a_fade_end: assert property ( // see RULE18
        @(posedge core_clk_in) disable iff (!resetn_in)
        last_step && !upd_in |=> done_out && !fading)
        else $error("fade end not flagged");
    a_hold_pending: assert property ( // see RULE5
        @(posedge core_clk_in) disable iff (!resetn_in)
        !upd_in && !step_now |=> $stable(duty_out))
        else $error("duty moved without update or step");
    a_fade_step: assert property ( // see RULE15
        @(posedge core_clk_in) disable iff (!resetn_in)
        step_now && !upd_in && dir |=> duty_out >= $past(duty_out))
        else $error("rising fade went down");
    c_fade_done: cover property (
        @(posedge core_clk_in) disable iff (!resetn_in) done_out);

endmodule : lpc_chan

// >>> lpc_top.sv
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
// How it works
// RULE1: Eight timers, sixteen channels, two speed groups
// RULE2: Fast-group timers reload settings at overflow
// RULE3: Slow-group timers reload only on software trigger
// RULE4: Duty runs from zero to resolution maximum
// RULE5: Duty and fade wait for channel update
// RULE6: One bit resolution gives fixed half duty
// RULE7: Divider and resolution trade frequency against precision
// RULE8: Resolution settable from one to fifteen bits
// RULE9: Hardware fade steps duty without processor help
// RULE10: Fade completion raises an enabled interrupt
// RULE11: Channel follows any timer of its group
// RULE12: Timer counter can reset, pause and resume
// RULE13: Stopped channel holds its idle level
// RULE14: Each group: four timers, eight channels
// RULE15: Step duty by scale every set periods
// RULE16: Fade holds steps, scale, direction, period count
// RULE17: Output active while count below duty
// RULE18: Fade ends after its steps, flag set
module lpc_top import lpc_pkg::*; #(
    parameter int DIV_W = LPC_DIV_W
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Pins and interrupt
    output logic [LPC_NUM_CH-1:0] pwm_out,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration check
    if (DIV_W < 1 || DIV_W > LPC_DIV_W) begin : g_bad_div
        $error("DIV_W must lie between 1 and the divider field width");
    end

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    lpc_tmr_cfg_s tmr_cfg [LPC_NUM_TMR];
    lpc_ch_cfg_s ch_cfg [LPC_NUM_CH];
    lpc_fade_s ch_fade [LPC_NUM_CH];
    logic [LPC_CNT_W-1:0] ch_duty [LPC_NUM_CH];
    logic [LPC_CNT_W-1:0] ch_now [LPC_NUM_CH];
    logic [LPC_NUM_TMR-1:0] tmr_upd;
    logic [LPC_NUM_CH-1:0] ch_upd;
    logic [LPC_NUM_CH-1:0] ch_done;
    logic [LPC_NUM_CH-1:0] int_st;
    logic [LPC_NUM_CH-1:0] int_mask;

    // Timer state
    logic [LPC_CNT_W-1:0] tcnt [LPC_NUM_TMR];
    logic [LPC_RES_W-1:0] act_res [LPC_NUM_TMR];
    logic [DIV_W-1:0] act_div [LPC_NUM_TMR];
    logic [DIV_W-1:0] pre [LPC_NUM_TMR];
    logic [LPC_NUM_TMR-1:0] tovf;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    wire aligned = (paddr_in[1:0] == 2'h0);
    wire tmr_hit = aligned & (paddr_in[11:5] == LPC_TMR_BASE[11:5]);
    wire ch_hit = aligned & (paddr_in[11:8] == LPC_CH_BASE[11:8]);
    wire st_hit = (paddr_in == LPC_INT_ST_ADDR);
    wire mask_hit = (paddr_in == LPC_INT_MASK_ADDR);
    wire any_hit = tmr_hit | ch_hit | st_hit | mask_hit;
    wire [2:0] tmr_idx = paddr_in[4:2];
    wire [3:0] ch_idx = paddr_in[7:4];
    wire [1:0] ch_word = paddr_in[3:2];
    // Request is in its access phase and not yet answered
    wire req = psel_in & penable_in & !pready_out;
    // Writes land on the edge that sees pready high
    wire wr = psel_in & penable_in & pready_out & pwrite_in;
    wire wr_tmr = wr & tmr_hit;
    wire wr_ch = wr & ch_hit;
    wire [31:0] w_tmr = pwdata_in & LPC_TMR_WMASK;
    wire [31:0] w_conf = pwdata_in & LPC_CH_WMASK;
    wire [31:0] w_fade = pwdata_in & LPC_FADE_WMASK;
    wire [LPC_NUM_CH-1:0] st_clr = (wr & st_hit) ?
                                   pwdata_in[LPC_NUM_CH-1:0] : '0;

    ////////////////////////////////////////////////////////////////////////
    // Read selection; the last channel word shows the live duty
    wire [31:0] rd_ch = (ch_word == LPC_CH_W_CONF) ? 32'(ch_cfg[ch_idx]) :
                        (ch_word == LPC_CH_W_DUTY) ? 32'(ch_duty[ch_idx]) :
                        (ch_word == LPC_CH_W_FADE) ? 32'(ch_fade[ch_idx]) :
                        32'(ch_now[ch_idx]);
    wire [31:0] rd_data = tmr_hit ? 32'(tmr_cfg[tmr_idx]) :
                          ch_hit ? rd_ch :
                          st_hit ? 32'(int_st) :
                          mask_hit ? 32'(int_mask) : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status: hardware set beats a same-cycle clear
    wire [LPC_NUM_CH-1:0] next_int_st = (int_st & ~st_clr) | ch_done;
    // Mask as it stands after this edge, so the line never lags a mask write
    wire [LPC_NUM_CH-1:0] next_int_mask = (wr & mask_hit) ?
                                          pwdata_in[LPC_NUM_CH-1:0] : int_mask;

    ////////////////////////////////////////////////////////////////////////
    // APB answer, one wait state so read data comes from a flop
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h00000000;
        end else begin
            pready_out <= req;
            pslverr_out <= req & !any_hit;
            prdata_out <= (req & !pwrite_in) ? rd_data : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt registers and output
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            int_st <= '0;
            int_mask <= '0;
            irq_out <= 1'b0;
        end else begin
            int_st <= next_int_st;
            if (wr & mask_hit) begin
                int_mask <= pwdata_in[LPC_NUM_CH-1:0]; // see RULE10
            end
            irq_out <= |(next_int_st & next_int_mask); // see RULE10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software settings and one-cycle update strobes
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < LPC_NUM_TMR; i++) begin
                tmr_cfg[i] <= '{res: LPC_RES_RST, default: '0};
            end
            for (int i = 0; i < LPC_NUM_CH; i++) begin
                ch_cfg[i] <= '0;
                ch_fade[i] <= '0;
                ch_duty[i] <= '0;
            end
            tmr_upd <= '0;
            ch_upd <= '0;
        end else begin
            tmr_upd <= '0;
            ch_upd <= '0;
            if (wr_tmr) begin
                tmr_cfg[tmr_idx] <= lpc_tmr_cfg_s'(w_tmr);
                tmr_upd[tmr_idx] <= pwdata_in[29]; // see RULE3
            end
            if (wr_ch && ch_word == LPC_CH_W_CONF) begin
                ch_cfg[ch_idx] <= lpc_ch_cfg_s'(w_conf);
                ch_upd[ch_idx] <= pwdata_in[5]; // see RULE5
            end
            if (wr_ch && ch_word == LPC_CH_W_DUTY) begin
                ch_duty[ch_idx] <= pwdata_in[LPC_CNT_W-1:0];
            end
            if (wr_ch && ch_word == LPC_CH_W_FADE) begin
                ch_fade[ch_idx] <= lpc_fade_s'(w_fade);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timers: prescaler then counter modulo the resolution
    for (genvar t = 0; t < LPC_NUM_TMR; t++) begin : g_tmr
        localparam bit FAST = (t < LPC_GRP_TMR); // see RULE1 RULE14
        wire rst = tmr_cfg[t].rst;
        wire halt = tmr_cfg[t].pause;
        wire [LPC_CNT_W-1:0] tmax = lpc_res_max(act_res[t]);
        // Finer resolution means more ticks per period
        wire tick = !rst & !halt & (pre[t] == act_div[t]); // see RULE7
        // Greater-or-equal so a coarser slow reload still wraps
        assign tovf[t] = tick & (tcnt[t] >= tmax);
        // Fast timers swap at a period boundary, never mid-period
        wire load = FAST ? (tovf[t] | rst) : tmr_upd[t]; // see RULE2 RULE3

        always_ff @(posedge core_clk_in) begin
            if (!resetn_in) begin
                act_res[t] <= LPC_RES_RST;
                act_div[t] <= '0;
            end else if (load) begin
                act_res[t] <= tmr_cfg[t].res; // see RULE8
                act_div[t] <= tmr_cfg[t].div[DIV_W-1:0];
            end
        end

        always_ff @(posedge core_clk_in) begin
            if (!resetn_in || rst) begin
                pre[t] <= '0; // see RULE12
                tcnt[t] <= '0;
            end else if (!halt) begin
                pre[t] <= tick ? '0 : DIV_W'(pre[t] + 1'b1);
                if (tick) begin
                    tcnt[t] <= tovf[t] ? '0
                             : LPC_CNT_W'(tcnt[t] + 1'b1); // see RULE17
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channels, each bound live to a timer of its own group
    for (genvar c = 0; c < LPC_NUM_CH; c++) begin : g_ch
        localparam logic [2:0] TBASE = 3'((c / LPC_GRP_CH) * LPC_GRP_TMR);
        wire [2:0] tsel = TBASE + {1'b0, ch_cfg[c].tsel}; // see RULE11

        lpc_chan u_chan (
            .core_clk_in(core_clk_in),
            .resetn_in(resetn_in),
            .cnt_in(tcnt[tsel]),
            .ovf_in(tovf[tsel]),
            .res_in(act_res[tsel]),
            .cfg_in(ch_cfg[c]),
            .upd_in(ch_upd[c]),
            .duty_in(ch_duty[c]),
            .fade_in(ch_fade[c]),
            .duty_out(ch_now[c]),
            .pwm_out(pwm_out[c]),
            .done_out(ch_done[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_fast_reload: assert property ( // see RULE2
        @(posedge core_clk_in) disable iff (!resetn_in)
        tovf[0] |=> act_res[0] == $past(tmr_cfg[0].res))
        else $error("fast timer missed reload at overflow");
    a_slow_hold: assert property ( // see RULE3
        @(posedge core_clk_in) disable iff (!resetn_in)
        !tmr_upd[4] |=> $stable(act_res[4]) && $stable(act_div[4]))
        else $error("slow timer reloaded without trigger");
    a_cnt_bound: assert property ( // see RULE17
        @(posedge core_clk_in) disable iff (!resetn_in)
        tcnt[0] <= lpc_res_max(act_res[0]))
        else $error("fast timer count passed its top");
    a_tmr_reset: assert property ( // see RULE12
        @(posedge core_clk_in) disable iff (!resetn_in)
        tmr_cfg[1].rst |=> tcnt[1] == '0)
        else $error("timer count not cleared by reset bit");
    a_tmr_pause: assert property ( // see RULE12
        @(posedge core_clk_in) disable iff (!resetn_in)
        tmr_cfg[2].pause && !tmr_cfg[2].rst |=> $stable(tcnt[2]))
        else $error("paused timer kept counting");
    a_irq_level: assert property ( // see RULE10
        @(posedge core_clk_in) disable iff (!resetn_in)
        irq_out == |(int_st & int_mask))
        else $error("interrupt line disagrees with status");
    a_done_sticky: assert property ( // see RULE10
        @(posedge core_clk_in) disable iff (!resetn_in)
        ch_done[0] |=> int_st[0])
        else $error("fade completion not recorded");
    a_apb_once: assert property (
        @(posedge core_clk_in) disable iff (!resetn_in)
        pready_out |=> !pready_out ##1 1'b1)
        else $error("pready held for two cycles");
    c_irq: cover property (
        @(posedge core_clk_in) disable iff (!resetn_in) irq_out);
    c_fast_ovf: cover property (
        @(posedge core_clk_in) disable iff (!resetn_in) tovf[0] ##1 tovf[0]);
    c_slow_upd: cover property (
        @(posedge core_clk_in) disable iff (!resetn_in) tmr_upd[4]);

endmodule : lpc_top

// >>> lpc_led_model.sv
`timescale 1ns/1ps
module lpc_led_model import lpc_pkg::*; (
    // Clock
    input wire logic core_clk_in,
    // Pins and measuring window
    input wire logic [LPC_NUM_CH-1:0] pwm_in,
    input wire logic win_in,
    // Lit cycles per pin
    output logic [LPC_NUM_CH-1:0][7:0] lit_out
);
    ////////////////////////////////////////////////////////////////////////
    // Count lit cycles inside the window; an LED only integrates light,
    // so phase within the window does not matter
    always_ff @(posedge core_clk_in) begin
        for (int c = 0; c < LPC_NUM_CH; c++) begin
            lit_out[c] <= win_in ? lit_out[c] + 8'(pwm_in[c]) : 8'h00;
        end
    end
endmodule : lpc_led_model

// >>> led_pwm_controller_bench.sv
`timescale 1ns/1ps
module led_pwm_controller_bench import lpc_pkg::*;;
    logic core_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic win = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic rerr;
    logic [31:0] rdata;
    logic [LPC_NUM_CH-1:0] pwm;
    logic [LPC_NUM_CH-1:0][7:0] lit;
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int d;
    int s;
    int n;

    lpc_top lpc_top_i (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .pwm_out(pwm),
        .irq_out(irq));
    lpc_led_model lpc_led_model_i (.core_clk_in(core_clk_in), .pwm_in(pwm),
        .win_in(win), .lit_out(lit));

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #5 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            end_sim();
        end
    end

    task end_sim;
        if (errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; the wait is bounded, never assumed
    task apb(input logic w, input logic [11:0] a, input logic [31:0] dt);
        int k;
        @(posedge core_clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dt;
        @(posedge core_clk_in);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk_in);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) chk(32'h0, 32'h1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task tmr(input int t, input logic [3:0] r, input logic [9:0] dv);
        // Clean start: hold the counter in reset while loading
        apb(1'b1, 12'(4 * t), 32'h20000000 | (32'(dv) << 16) | 32'(r));
        apb(1'b1, 12'(4 * t), (32'(dv) << 16) | 32'(r));
    endtask : tmr

    task chan(input int c, input logic [31:0] conf, input logic [31:0] dt);
        apb(1'b1, 12'h104 + 12'(16 * c), dt);
        apb(1'b1, 12'h100 + 12'(16 * c), conf | 32'h20);
    endtask : chan

    // Forty-cycle window, a whole number of every period used here
    task meas;
        repeat (4) @(posedge core_clk_in);
        win <= 1'b1;
        repeat (40) @(posedge core_clk_in);
        win <= 1'b0;
        #1;
    endtask : meas

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        s = $urandom(32'h5470d67f);
        repeat (4) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rdata, 32'h0000000D);
        apb(1'b0, 12'h0FC, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rdata, 32'h0);
        // Pending duty waits for the update strobe, then is clipped
        tmr(0, 4'h2, 10'h000);
        chan(0, 32'h8, 32'h1);
        apb(1'b1, 12'h104, 32'h3);
        apb(1'b0, 12'h10C, 32'h0);
        chk(rdata, 32'h1);
        apb(1'b1, 12'h104, 32'h7FFF);
        apb(1'b1, 12'h100, 32'h28);
        apb(1'b0, 12'h10C, 32'h0);
        chk(rdata, 32'h3);
        for (int i = 0; i < 4; i++) begin
            d = $urandom_range(3);
            chan(0, 32'h8, 32'(d));
            meas();
            chk(32'(lit[0]), 32'(d * 10));
        end
        // Fast timer adopts a new resolution at overflow, no trigger
        apb(1'b1, 12'h000, 32'h3);
        chan(0, 32'h8, 32'h1);
        meas();
        chk(32'(lit[0]), 32'd5);
        // Rebinding to a one-bit timer gives fixed half duty
        tmr(1, 4'h1, 10'h001);
        chan(0, 32'h9, 32'h0);
        meas();
        chk(32'(lit[0]), 32'd20);
        // Slow timer keeps its settings until the trigger
        tmr(4, 4'h3, 10'h000);
        chan(8, 32'h8, 32'h5);
        meas();
        chk(32'(lit[8]), 32'd25);
        apb(1'b1, 12'h010, 32'h2);
        repeat (20) @(posedge core_clk_in);
        meas();
        chk(32'(lit[8]), 32'd25);
        tmr(4, 4'h2, 10'h000);
        meas();
        chk(32'(lit[8]), 32'd30);
        // Stopped channels show the idle level
        for (int c = 0; c < 16; c += 9) begin
            d = $urandom_range(1);
            chan(c, 32'(d) << 4, 32'h1);
            meas();
            chk(32'(lit[c]), 32'(d * 40));
        end
        // Up fade of three steps, one period each, random scale
        tmr(2, 4'h4, 10'h000);
        apb(1'b1, 12'h084, 32'h4);
        s = $urandom_range(4, 1);
        apb(1'b1, 12'h128, 32'h80000403 | (32'(s) << 20));
        chan(2, 32'hA, 32'h0);
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(posedge core_clk_in);
            n++;
        end
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, 12'h12C, 32'h0);
        chk(rdata, 32'(3 * s));
        apb(1'b0, 12'h080, 32'h0);
        chk(rdata & 32'h4, 32'h4);
        // Mask, unmask, then clear by writing one
        apb(1'b1, 12'h084, 32'h0);
        repeat (2) @(posedge core_clk_in);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 12'h084, 32'h4);
        repeat (2) @(posedge core_clk_in);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 12'h080, 32'h4);
        repeat (2) @(posedge core_clk_in);
        chk({31'h0, irq}, 32'h0);
        // Down fade saturates at zero; its status bit stays masked
        apb(1'b1, 12'h138, 32'h00500802);
        chan(3, 32'h8, 32'h7);
        repeat (80) @(posedge core_clk_in);
        apb(1'b0, 12'h13C, 32'h0);
        chk(rdata, 32'h0);
        apb(1'b0, 12'h080, 32'h0);
        chk(rdata & 32'h8, 32'h8);
        chk({31'h0, irq}, 32'h0);
        // Paused timer freezes its count at zero, so the pin stays lit
        apb(1'b1, 12'h008, 32'h30000004);
        apb(1'b1, 12'h008, 32'h10000004);
        meas();
        chk(32'(lit[2]), 32'd40);
        end_sim();
    end
endmodule : led_pwm_controller_bench
